// ===== rtl/dmc_mode_regs.sv
// Function
// - Reset bit write clears all registers
// - Reset bit returns to zero itself
// - Sleep held during software reset
// - Registers at addresses 00h to 04h
// - Format bit 7 disables duty stabilizer
// - Format bit 6 enables scrambler
// - Scrambler XORs upper bits with LSB
// - Format bit 5 selects two's complement
// - Sleep and nap decode from bits
// - Nap bits act independently
// - Output bits 7-5 select current
// - Termination bit doubles driver current
// - Output bit 3 disables drivers
// - Pattern high bit 7 forces pattern
// - Pattern high bits 5-0 give 13-8
// - Pattern low byte gives bits 7-0
// - Forced pattern overrides formatting
`timescale 1ns/100ps
`default_nettype none
`include "dmc_consts.svh"
module dmc_mode_regs
  import dmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic serialClk,
  input wire logic serialCsN,
  input wire logic serialDataIn,
  output logic configDataOut,
  output logic configDataOutOe,
  input wire dmc_sample_t chan1Sample,
  input wire dmc_sample_t chan2Sample,
  output dmc_sample_t chan1Data,
  output dmc_sample_t chan2Data,
  output logic dutyStabilizerDisable,
  output logic outputScrambleEnable,
  output logic signedFormatSelect,
  output logic sleepMode,
  output logic chan1Nap,
  output logic chan2Nap,
  output logic chan1Enable,
  output logic chan2Enable,
  output logic [2:0] driverCurrentSel,
  output logic [7:0] driveCurrentCode,
  output logic onChipTerminationEnable,
  output logic outputDriversOff,
  output logic [2:0] laneSerializationSel,
  output logic laneTwoMode,
  output logic [4:0] serialWordBits,
  output logic laneModeValid,
  output logic patternForceEnable,
  output logic softResetBusy
);
  dmc_cfg_if cfgBus ();

  logic [2:0] wrSync_q;
  logic wrSeen_q;
  logic wrEvt;
  logic srstHit;
  dmc_byte_t format_q;
  dmc_byte_t outMode_q;
  dmc_byte_t patHigh_q;
  dmc_byte_t patLow_q;
  logic [2:0] srstCnt_q;
  logic imgToggle_q;
  logic srstBusy;
  dmc_byte_t baseCurrent;

  function automatic logic [7:0] currentCode(input logic [2:0] sel);
    case (sel)
      3'b000: currentCode = `DMC_CUR_3P5;
      3'b001: currentCode = `DMC_CUR_4P0;
      3'b010: currentCode = `DMC_CUR_4P5;
      3'b100: currentCode = `DMC_CUR_3P0;
      3'b101: currentCode = `DMC_CUR_2P5;
      3'b110: currentCode = `DMC_CUR_2P1;
      3'b111: currentCode = `DMC_CUR_1P75;
      default: currentCode = `DMC_CUR_NONE;
    endcase
  endfunction : currentCode

  // ============================================================
  // Serial port on the link clock
  dmc_serial_port serialPort (
    .serialClk(serialClk),
    .serialCsN(serialCsN),
    .serialDataIn(serialDataIn),
    .reset(reset),
    .configDataOut(configDataOut),
    .configDataOutOe(configDataOutOe),
    .cfg(cfgBus.serial)
  );

  // ============================================================
  // Write event crossing; address and data stay still long after the toggle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wrSync_q <= 3'h0;
      wrSeen_q <= 1'b0;
    end else begin
      wrSync_q <= {wrSync_q[1:0], cfgBus.wrToggle};
      if (wrEvt) begin
        wrSeen_q <= wrSync_q[2];
      end
    end
  end

  assign wrEvt = (wrSync_q[1] == wrSync_q[2]) && (wrSync_q[2] != wrSeen_q);
  assign srstHit = wrEvt && cfgBus.wrAddr == `DMC_ADDR_RESET && cfgBus.wrData[`DMC_SRST_BIT];
  assign srstBusy = srstCnt_q != 3'h0;

  // ============================================================
  // Software reset sequencing
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      srstCnt_q <= 3'h0;
    end else if (srstHit) begin
      srstCnt_q <= `DMC_SRST_HOLD;
    end else if (srstBusy) begin
      srstCnt_q <= srstCnt_q - 3'h1;
    end
  end

  // ============================================================
  // Mode registers; masks keep don't-care bits at zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      format_q <= `DMC_REG_RESET;
      outMode_q <= `DMC_REG_RESET;
      patHigh_q <= `DMC_REG_RESET;
      patLow_q <= `DMC_REG_RESET;
    end else if (srstHit) begin
      format_q <= `DMC_REG_RESET;
      outMode_q <= `DMC_REG_RESET;
      patHigh_q <= `DMC_REG_RESET;
      patLow_q <= `DMC_REG_RESET;
    end else if (wrEvt) begin
      case (cfgBus.wrAddr)
        `DMC_ADDR_FORMAT: format_q <= cfgBus.wrData & `DMC_FORMAT_MASK;
        `DMC_ADDR_OUTPUT: outMode_q <= cfgBus.wrData & `DMC_OUTPUT_MASK;
        `DMC_ADDR_PAT_HIGH: patHigh_q <= cfgBus.wrData & `DMC_PAT_HIGH_MASK;
        `DMC_ADDR_PAT_LOW: patLow_q <= cfgBus.wrData & `DMC_PAT_LOW_MASK;
        default: format_q <= format_q;
      endcase
    end
  end

  // Image for readback; toggle flips on every change so the link side refreshes
  // A soft reset flips only at its end: two flips between frames would cancel
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      imgToggle_q <= 1'b0;
    end else if ((wrEvt && !srstHit) || srstCnt_q == 3'h1) begin
      imgToggle_q <= ~imgToggle_q;
    end
  end

  assign cfgBus.imgToggle = imgToggle_q;
  assign cfgBus.image = {patLow_q, patHigh_q, outMode_q, format_q, srstBusy, 7'h00};

  // ============================================================
  // Control outputs
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dutyStabilizerDisable <= 1'b0;
      outputScrambleEnable <= 1'b0;
      signedFormatSelect <= 1'b0;
      sleepMode <= 1'b0;
      chan1Nap <= 1'b0;
      chan2Nap <= 1'b0;
      // Zeroed registers mean normal operation, so channels start enabled
      chan1Enable <= 1'b1;
      chan2Enable <= 1'b1;
      softResetBusy <= 1'b0;
    end else begin
      dutyStabilizerDisable <= format_q[`DMC_FMT_DCS_BIT];
      outputScrambleEnable <= format_q[`DMC_FMT_SCRAMBLE_BIT];
      signedFormatSelect <= format_q[`DMC_FMT_SIGNED_BIT];
      sleepMode <= format_q[`DMC_FMT_SLEEP_BIT] | srstBusy;
      chan1Nap <= format_q[`DMC_FMT_NAP1_BIT];
      chan2Nap <= format_q[`DMC_FMT_NAP2_BIT];
      chan1Enable <= ~(format_q[`DMC_FMT_SLEEP_BIT] | srstBusy | format_q[`DMC_FMT_NAP1_BIT]);
      chan2Enable <= ~(format_q[`DMC_FMT_SLEEP_BIT] | srstBusy | format_q[`DMC_FMT_NAP2_BIT]);
      softResetBusy <= srstBusy;
    end
  end

  // Reserved current code 011 yields zero; termination with high codes is left to the host
  assign baseCurrent = currentCode(outMode_q[7:5]);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      driverCurrentSel <= 3'h0;
      driveCurrentCode <= `DMC_CUR_3P5;
      onChipTerminationEnable <= 1'b0;
      outputDriversOff <= 1'b0;
    end else begin
      driverCurrentSel <= outMode_q[7:5];
      driveCurrentCode <= outMode_q[`DMC_OUT_TERM_BIT] ?
        {baseCurrent[6:0], 1'b0} : baseCurrent;
      onChipTerminationEnable <= outMode_q[`DMC_OUT_TERM_BIT];
      outputDriversOff <= outMode_q[`DMC_OUT_OFF_BIT];
    end
  end

  // Codes outside the four known modes are flagged and fall back to two lanes at 16 bits
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      laneSerializationSel <= 3'h0;
      laneTwoMode <= 1'b1;
      serialWordBits <= 5'h10;
      laneModeValid <= 1'b1;
    end else begin
      laneSerializationSel <= outMode_q[2:0];
      case (outMode_q[2:0])
        DMC_LANE2_16: begin
          laneTwoMode <= 1'b1;
          serialWordBits <= 5'h10;
          laneModeValid <= 1'b1;
        end
        DMC_LANE2_14: begin
          laneTwoMode <= 1'b1;
          serialWordBits <= 5'h0E;
          laneModeValid <= 1'b1;
        end
        DMC_LANE2_12: begin
          laneTwoMode <= 1'b1;
          serialWordBits <= 5'h0C;
          laneModeValid <= 1'b1;
        end
        DMC_LANE1_14: begin
          laneTwoMode <= 1'b0;
          serialWordBits <= 5'h0E;
          laneModeValid <= 1'b1;
        end
        default: begin
          laneTwoMode <= 1'b1;
          serialWordBits <= 5'h10;
          laneModeValid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      patternForceEnable <= 1'b0;
    end else begin
      patternForceEnable <= patHigh_q[`DMC_PAT_FORCE_BIT];
    end
  end

  // ============================================================
  // Data path formatting
  dmc_formatter formatter (
    .sys_clk(sys_clk),
    .reset(reset),
    .chan1In(chan1Sample),
    .chan2In(chan2Sample),
    .scramble(format_q[`DMC_FMT_SCRAMBLE_BIT]),
    .signedFmt(format_q[`DMC_FMT_SIGNED_BIT]),
    .patternForce(patHigh_q[`DMC_PAT_FORCE_BIT]),
    .pattern({patHigh_q[5:0], patLow_q}),
    .chan1Out(chan1Data),
    .chan2Out(chan2Data)
  );

  // ============================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_srst_clear;
    srstHit |=> format_q == 8'h00 && outMode_q == 8'h00 && patHigh_q == 8'h00 && patLow_q == 8'h00;
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("soft reset left data");

  property p_srst_end;
    srstHit |=> srstBusy [*4] ##1 !srstBusy;
  endproperty
  a_srst_end: assert property (p_srst_end) else $error("reset bit did not self clear");

  property p_srst_sleep;
    srstBusy |=> sleepMode && !chan1Enable && !chan2Enable;
  endproperty
  a_srst_sleep: assert property (p_srst_sleep) else $error("no sleep during reset");

  property p_write_format;
    wrEvt && !srstHit && cfgBus.wrAddr == 7'h01 |=> format_q == ($past(cfgBus.wrData) & 8'hF9);
  endproperty
  a_write_format: assert property (p_write_format) else $error("format write lost");

  property p_write_low;
    wrEvt && !srstHit && cfgBus.wrAddr == 7'h04 |=> patLow_q == $past(cfgBus.wrData);
  endproperty
  a_write_low: assert property (p_write_low) else $error("pattern low write lost");

  property p_dcs;
    ##1 dutyStabilizerDisable == $past(format_q[7]) && outputScrambleEnable == $past(format_q[6]);
  endproperty
  a_dcs: assert property (p_dcs) else $error("format controls stale");

  property p_naps;
    !sleepMode |-> chan1Enable == !chan1Nap && chan2Enable == !chan2Nap;
  endproperty
  a_naps: assert property (p_naps) else $error("nap enables disagree");

  property p_term;
    onChipTerminationEnable && driverCurrentSel == 3'b111 |-> driveCurrentCode == 8'h46;
  endproperty
  a_term: assert property (p_term) else $error("termination current not doubled");

  property p_dontcare;
    format_q[2:1] == 2'b00 && patHigh_q[6] == 1'b0;
  endproperty
  a_dontcare: assert property (p_dontcare) else $error("don't care bit stored");

  property p_output_drivers_off;
    ##1 outputDriversOff == $past(outMode_q[3]);
  endproperty
  a_output_drivers_off: assert property (p_output_drivers_off) else $error("driver disable stale");

  property p_sleep;
    format_q[`DMC_FMT_SLEEP_BIT] |=> sleepMode && !chan1Enable && !chan2Enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep left a channel on");

  property p_one_lane;
    outMode_q[2:0] == DMC_LANE1_14 |=> !laneTwoMode && serialWordBits == 5'h0E && laneModeValid;
  endproperty
  a_one_lane: assert property (p_one_lane) else $error("one lane mode wrong");

  property p_pat_force;
    ##1 patternForceEnable == $past(patHigh_q[`DMC_PAT_FORCE_BIT]);
  endproperty
  a_pat_force: assert property (p_pat_force) else $error("pattern force stale");

  c_srst: cover property (srstHit ##5 !srstBusy);
  c_force: cover property (patternForceEnable && outputScrambleEnable);
  c_two_naps: cover property (chan1Nap && chan2Nap && !sleepMode);
endmodule : dmc_mode_regs
`default_nettype wire

// ===== rtl/dmc_consts.svh
`ifndef DMC_CONSTS_SVH
`define DMC_CONSTS_SVH

// ============================================================
// Register addresses
`define DMC_ADDR_RESET 7'h00
`define DMC_ADDR_FORMAT 7'h01
`define DMC_ADDR_OUTPUT 7'h02
`define DMC_ADDR_PAT_HIGH 7'h03
`define DMC_ADDR_PAT_LOW 7'h04
`define DMC_REG_COUNT 3'h5

// ============================================================
// Reset values and write masks
`define DMC_REG_RESET 8'h00
`define DMC_FORMAT_MASK 8'hF9
`define DMC_OUTPUT_MASK 8'hFF
`define DMC_PAT_HIGH_MASK 8'hBF
`define DMC_PAT_LOW_MASK 8'hFF

// ============================================================
// Field positions
`define DMC_SRST_BIT 7
`define DMC_FMT_DCS_BIT 7
`define DMC_FMT_SCRAMBLE_BIT 6
`define DMC_FMT_SIGNED_BIT 5
`define DMC_FMT_SLEEP_BIT 4
`define DMC_FMT_NAP2_BIT 3
`define DMC_FMT_NAP1_BIT 0
`define DMC_OUT_TERM_BIT 4
`define DMC_OUT_OFF_BIT 3
`define DMC_PAT_FORCE_BIT 7

// ============================================================
// Serial word and timing counts
`define DMC_WORD_EDGES 5'h10
`define DMC_LAST_EDGE 5'h0F
`define DMC_READ_START 5'h08
`define DMC_SRST_HOLD 3'h4

// ============================================================
// Driver current in units of 0.05 mA
`define DMC_CUR_3P5 8'h46
`define DMC_CUR_4P0 8'h50
`define DMC_CUR_4P5 8'h5A
`define DMC_CUR_3P0 8'h3C
`define DMC_CUR_2P5 8'h32
`define DMC_CUR_2P1 8'h2A
`define DMC_CUR_1P75 8'h23
`define DMC_CUR_NONE 8'h00

`endif

// ===== rtl/dmc_pkg.sv
`default_nettype none
package dmc_pkg;
  typedef logic [7:0] dmc_byte_t;
  typedef logic [13:0] dmc_sample_t;
  typedef logic [39:0] dmc_image_t;
  typedef enum logic [2:0] {
    DMC_LANE2_16 = 3'b000,
    DMC_LANE2_14 = 3'b001,
    DMC_LANE2_12 = 3'b010,
    DMC_LANE1_14 = 3'b101
  } dmc_lane_t;
endpackage : dmc_pkg
`default_nettype wire

// ===== rtl/dmc_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dmc_cfg_if;
  import dmc_pkg::*;
  logic wrToggle;
  logic [6:0] wrAddr;
  dmc_byte_t wrData;
  logic imgToggle;
  dmc_image_t image;
  modport serial (output wrToggle, output wrAddr, output wrData, input imgToggle, input image);
  modport regs (input wrToggle, input wrAddr, input wrData, output imgToggle, output image);
endinterface : dmc_cfg_if
`default_nettype wire

// ===== rtl/dmc_serial_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "dmc_consts.svh"
module dmc_serial_port
  import dmc_pkg::*;
(
  input wire logic serialClk,
  input wire logic serialCsN,
  input wire logic serialDataIn,
  input wire logic reset,
  output logic configDataOut,
  output logic configDataOutOe,
  dmc_cfg_if.serial cfg
);
  logic frameRst;
  logic [4:0] bitCnt_q;
  logic [15:0] shift_q;
  logic [15:0] word_d;
  logic wrToggle_q;
  logic [6:0] wrAddr_q;
  dmc_byte_t wrData_q;
  logic [2:0] imgSync_q;
  logic imgSeen_q;
  dmc_image_t shadow_q;
  dmc_byte_t rdByte_q;
  logic sdoLow_q;
  logic rdActive_q;
  dmc_byte_t rdPick;

  function automatic dmc_byte_t pickByte(input dmc_image_t img, input logic [6:0] addr);
    if (addr < {4'h0, `DMC_REG_COUNT}) begin
      pickByte = img[8 * addr[2:0] +: 8];
    end else begin
      pickByte = `DMC_REG_RESET;
    end
  endfunction : pickByte

  // ============================================================
  // Word capture; frame logic clears whenever chip select is high
  assign frameRst = serialCsN | reset;
  assign word_d = {shift_q[14:0], serialDataIn};

  always_ff @(posedge serialClk or posedge frameRst) begin
    if (frameRst) begin
      bitCnt_q <= 5'h00;
      shift_q <= 16'h0000;
    end else if (bitCnt_q != `DMC_WORD_EDGES) begin
      bitCnt_q <= bitCnt_q + 5'h01;
      shift_q <= word_d;
    end
  end

  // Write data is held until the next write, so the other side samples it calmly
  always_ff @(posedge serialClk or posedge reset) begin
    if (reset) begin
      wrToggle_q <= 1'b0;
      wrAddr_q <= 7'h00;
      wrData_q <= 8'h00;
    end else if (bitCnt_q == `DMC_LAST_EDGE && !shift_q[14]) begin
      wrToggle_q <= ~wrToggle_q;
      wrAddr_q <= shift_q[13:7];
      wrData_q <= word_d[7:0];
    end
  end

  // ============================================================
  // Register image shadow, refreshed once the toggle settles
  always_ff @(posedge serialClk or posedge reset) begin
    if (reset) begin
      imgSync_q <= 3'h0;
      imgSeen_q <= 1'b0;
      shadow_q <= 40'h00_0000_0000;
    end else begin
      imgSync_q <= {imgSync_q[1:0], cfg.imgToggle};
      if (imgSync_q[1] == imgSync_q[2] && imgSync_q[2] != imgSeen_q) begin
        imgSeen_q <= imgSync_q[2];
        shadow_q <= cfg.image;
      end
    end
  end

  // ============================================================
  // Readback, open drain, changed on falling clock edges
  // Line stays released during write frames, so the pull-up holds it high
  assign rdPick = pickByte(shadow_q, shift_q[6:0]);

  always_ff @(negedge serialClk or posedge frameRst) begin
    if (frameRst) begin
      rdByte_q <= 8'h00;
      sdoLow_q <= 1'b0;
      rdActive_q <= 1'b0;
    end else if (bitCnt_q == `DMC_READ_START && shift_q[7]) begin
      rdActive_q <= 1'b1;
      rdByte_q <= {rdPick[6:0], 1'b0};
      sdoLow_q <= ~rdPick[7];
    end else if (rdActive_q && bitCnt_q < `DMC_WORD_EDGES) begin
      rdByte_q <= {rdByte_q[6:0], 1'b0};
      sdoLow_q <= ~rdByte_q[7];
    end else begin
      sdoLow_q <= 1'b0;
    end
  end

  assign configDataOut = 1'b0;
  assign configDataOutOe = sdoLow_q;
  assign cfg.wrToggle = wrToggle_q;
  assign cfg.wrAddr = wrAddr_q;
  assign cfg.wrData = wrData_q;
endmodule : dmc_serial_port
`default_nettype wire

// ===== rtl/dmc_formatter.sv
`timescale 1ns/100ps
`default_nettype none
module dmc_formatter
  import dmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire dmc_sample_t chan1In,
  input wire dmc_sample_t chan2In,
  input wire logic scramble,
  input wire logic signedFmt,
  input wire logic patternForce,
  input wire dmc_sample_t pattern,
  output dmc_sample_t chan1Out,
  output dmc_sample_t chan2Out
);
  function automatic dmc_sample_t fmtSample(input dmc_sample_t d, input logic sc,
                                            input logic sg, input logic fo,
                                            input dmc_sample_t pat);
    dmc_sample_t v;
    v = sg ? {~d[13], d[12:0]} : d;
    if (sc) begin
      v = {v[13:1] ^ {13{v[0]}}, v[0]};
    end
    fmtSample = fo ? pat : v;
  endfunction : fmtSample

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      chan1Out <= 14'h0000;
      chan2Out <= 14'h0000;
    end else begin
      chan1Out <= fmtSample(chan1In, scramble, signedFmt, patternForce, pattern);
      chan2Out <= fmtSample(chan2In, scramble, signedFmt, patternForce, pattern);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_scramble;
    !patternForce && scramble && !signedFmt |=>
      chan1Out == {$past(chan1In[13:1]) ^ {13{$past(chan1In[0])}}, $past(chan1In[0])};
  endproperty
  a_scramble: assert property (p_scramble) else $error("scrambled sample wrong");

  property p_signed;
    !patternForce && !scramble && signedFmt |=>
      chan2Out == {~$past(chan2In[13]), $past(chan2In[12:0])};
  endproperty
  a_signed: assert property (p_signed) else $error("signed sample wrong");

  property p_force;
    patternForce |=> chan1Out == $past(pattern) && chan2Out == $past(pattern);
  endproperty
  a_force: assert property (p_force) else $error("pattern not forced");
endmodule : dmc_formatter
`default_nettype wire

// ===== test/dmc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Host side of the serial configuration port
module dmc_host_model (
  input wire logic linkClk,
  input wire logic sdoOe,
  output logic serialClk,
  output logic serialCsN,
  output logic serialDataIn
);
  // Extra low-phase cycles per bit, for a slow host
  int stretch = 0;
  // Line has a pull-up; it reads low only while pulled
  wire logic sdoLevel = ~sdoOe;
  initial begin
    serialClk = 1'b0;
    serialCsN = 1'b1;
    serialDataIn = 1'b1;
  end
  // Clock stands low outside frames
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d,
                      input int nEdges, output logic [7:0] rd);
    logic [15:0] word;
    word = {rw, a, d};
    rd = 8'h00;
    @(posedge linkClk);
    serialCsN <= 1'b0;
    for (int i = 0; i < nEdges; i++) begin
      @(posedge linkClk);
      serialClk <= 1'b0;
      serialDataIn <= word[15-i];
      repeat (stretch) @(posedge linkClk);
      @(posedge linkClk);
      if (i >= 8) rd[15-i] = sdoLevel;
      serialClk <= 1'b1;
    end
    @(posedge linkClk);
    serialClk <= 1'b0;
    // Released data line must not keep a plausible value
    serialDataIn <= ~serialDataIn;
    @(posedge linkClk);
    serialCsN <= 1'b1;
  endtask : xfer
endmodule : dmc_host_model
`default_nettype wire

// ===== test/dmc_mode_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module dmc_mode_regs_tb_top
  import dmc_pkg::*;
;
  logic sys_clk, reset, linkClk;
  dmc_sample_t s1, s2, d1, d2;
  wire logic sck, csN, sdi, sdoOe;
  logic dcs, scr, sgn, slp, n1, n2, e1, e2, term, off, two, lv, pf, busy;
  logic [2:0] cur, lane;
  logic [7:0] curCode;
  logic [4:0] wbits;
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] regs[5];
  logic [7:0] masks[5] = '{8'h00, 8'hF9, 8'hFF, 8'hBF, 8'hFF};
  logic [7:0] units[8] = '{8'h46, 8'h50, 8'h5A, 8'h00, 8'h3C, 8'h32, 8'h2A, 8'h23};
  dmc_mode_regs dut_u (.sys_clk(sys_clk), .reset(reset), .serialClk(sck), .serialCsN(csN),
    .serialDataIn(sdi), .configDataOut(), .configDataOutOe(sdoOe), .chan1Sample(s1),
    .chan2Sample(s2), .chan1Data(d1), .chan2Data(d2), .dutyStabilizerDisable(dcs),
    .outputScrambleEnable(scr), .signedFormatSelect(sgn), .sleepMode(slp), .chan1Nap(n1),
    .chan2Nap(n2), .chan1Enable(e1), .chan2Enable(e2), .driverCurrentSel(cur),
    .driveCurrentCode(curCode), .onChipTerminationEnable(term), .outputDriversOff(off),
    .laneSerializationSel(lane), .laneTwoMode(two), .serialWordBits(wbits),
    .laneModeValid(lv), .patternForceEnable(pf), .softResetBusy(busy));
  dmc_host_model host_u (.linkClk(linkClk), .sdoOe(sdoOe), .serialClk(sck),
    .serialCsN(csN), .serialDataIn(sdi));
  // ============================================================
  // Checks
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_port
  function automatic dmc_sample_t fmt(input dmc_sample_t s);
    dmc_sample_t t;
    t = s ^ {regs[1][5], 13'h0000};
    if (regs[1][6]) t[13:1] = t[13:1] ^ {13{t[0]}};
    if (regs[3][7]) t = {regs[3][5:0], regs[4]};
    return t;
  endfunction : fmt
  // ============================================================
  // Register access
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rd;
    host_u.xfer(1'b0, a, d, 16, rd);
    if (a < 7'h05) regs[a] = d & masks[a];
    repeat (10) @(posedge sys_clk);
  endtask : wr
  task automatic rd_chk(input logic [6:0] a);
    logic [7:0] rd;
    // Data sent during a read must be ignored
    host_u.xfer(1'b1, a, 8'($urandom), 16, rd);
    chk_reg(rd, (a < 7'h05) ? regs[a] : 8'h00);
    repeat (2) @(posedge sys_clk);
  endtask : rd_chk
  task automatic chk_outs();
    logic [7:0] f, o;
    logic [2:0] l;
    logic [4:0] w;
    f = regs[1];
    o = regs[2];
    l = o[2:0];
    w = (l == 3'h1 || l == 3'h5) ? 5'h0E : (l == 3'h2) ? 5'h0C : 5'h10;
    @(negedge sys_clk);
    chk_port({dcs, scr, sgn, slp, n1, n2, e1, e2},
      {f[7:4], f[0], f[3], ~(f[4] | f[0]), ~(f[4] | f[3])});
    chk_port({cur, term, off, lane}, o);
    chk_port(curCode, units[o[7:5]] << o[4]);
    chk_port({two, wbits, lv}, {l != 3'h5, w, l inside {3'h0, 3'h1, 3'h2, 3'h5}});
    chk_port(pf, regs[3][7]);
  endtask : chk_outs
  task automatic srst();
    logic [7:0] rd;
    int n;
    host_u.xfer(1'b0, 7'h00, 8'hFF, 16, rd);
    regs = '{default: 8'h00};
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk_port({busy, slp, e1, e2}, 16'h000C);
    repeat (10) @(posedge sys_clk);
    rd_chk(7'h00);
    chk_outs();
    $display("soft reset test done");
  endtask : srst
  task automatic chk_fmt();
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk);
      s1 <= dmc_sample_t'($urandom);
      s2 <= dmc_sample_t'($urandom);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk_port(d1, fmt(s1));
      chk_port(d2, fmt(s2));
    end
  endtask : chk_fmt
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  // ============================================================
  // Clocks, watchdog and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    linkClk = 1'b0;
    #3.7;
    forever #3 linkClk = ~linkClk;
  end
  initial begin
    #1000000;
    mismatches++;
    wrap_up();
  end
  initial begin
    logic [7:0] rd;
    reset = 1'b1;
    s1 = 14'h0000;
    s2 = 14'h0000;
    regs = '{default: 8'h00};
    void'($urandom(32'h925dc096));
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_outs();
    srst();
    for (int k = 0; k < 3; k++) begin
      for (int a = 1; a < 6; a++) begin
        // Termination stays off here: high currents may be drawn
        wr(7'(a), 8'($urandom) & ((a == 2) ? 8'hEF : 8'hFF));
        rd_chk(7'(a));
      end
      chk_outs();
    end
    $display("readback test done");
    for (int i = 0; i < 8; i++) begin
      wr(7'h01, {3'h0, i[2], i[1], 2'h3, i[0]});
      chk_outs();
    end
    $display("power mode test done");
    for (int k = 0; k < 11; k++) begin
      wr(7'h02, {(k < 8) ? 3'(k) : 3'(k - 3), k >= 8, k[0], 3'(k)});
      chk_outs();
    end
    $display("output mode test done");
    // Hardware reset in mid-run must bring every register back to zero
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    regs = '{default: 8'h00};
    repeat (2) @(posedge sys_clk);
    chk_outs();
    rd_chk(7'h02);
    $display("hardware reset test done");
    wr(7'h01, 8'h00);
    repeat (100) @(posedge sys_clk);
    host_u.stretch = 2;
    for (int j = 0; j < 4; j++) begin
      // Every mix of scrambler and signed format is visited once
      wr(7'h01, (8'($urandom) & 8'h86) | {1'b0, 2'(j), 5'h00});
      wr(7'h03, 8'($urandom) & 8'h7F);
      wr(7'h04, 8'($urandom));
      chk_fmt();
      wr(7'h03, 8'($urandom) | 8'h80);
      rd_chk(7'h03);
      chk_fmt();
    end
    host_u.stretch = 0;
    $display("formatter test done");
    // A frame cut short must leave the register alone
    host_u.xfer(1'b0, 7'h01, 8'hFF, 12, rd);
    repeat (10) @(posedge sys_clk);
    rd_chk(7'h01);
    srst();
    rd_chk(7'h01);
    wrap_up();
  end
endmodule : dmc_mode_regs_tb_top
`default_nettype wire
